//--- verilog/sadc_pkg.sv
// constants for the two-channel result and control block
package sadc_pkg;
    localparam int          ADDR_W    = 18;
    localparam int          RES_W     = 12;
    localparam int          NCH       = 2;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_R0L   = 16'hf2d0;
    localparam logic [15:0] IDX_R0H   = 16'hf2d1;
    localparam logic [15:0] IDX_R1L   = 16'hf2d2;
    localparam logic [15:0] IDX_R1H   = 16'hf2d3;
    localparam logic [15:0] IDX_CON0  = 16'hf2f0;
    localparam logic [15:0] IDX_CON1  = 16'hf2f1;
    localparam logic [15:0] IDX_MOD0  = 16'hf2f2;
    localparam logic [15:0] IDX_STAT  = 16'hf2f4;
    localparam logic [15:0] IDX_MASK  = 16'hf2f5;
    // reset values
    localparam logic [7:0]  CON0_RST  = 8'h02;
    localparam logic [7:0]  CON1_RST  = 8'h00;
    localparam logic [7:0]  MOD0_RST  = 8'h00;
    // field positions
    localparam int          REP_BIT   = 0;
    localparam int          RUN_BIT   = 0;
    localparam int          NIB_POS   = 4;
    // bus answers
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;
endpackage

//--- verilog/sadc_seq_if.sv
// channel sequencer link between register file and sequencer
`timescale 1ns/10ps
`default_nettype none
interface sadc_seq_if;
    logic        run;
    logic        repeat_sel;
    logic [1:0]  sel;
    logic        clear_run;
    logic [1:0]  store;
    logic [11:0] data;
    logic        start;
    logic        ch;
    logic        done;
    logic [11:0] result;
    modport ctl (output run, repeat_sel, sel, done, result,
                 input clear_run, store, data, start, ch);
    modport seq (input run, repeat_sel, sel, done, result,
                 output clear_run, store, data, start, ch);
endinterface
`default_nettype wire

//--- verilog/sadc_seq.sv
// channel sequencer: start, wait for done, next channel or stop
`timescale 1ns/10ps
`default_nettype none
module sadc_seq
    import sadc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    sadc_seq_if.seq   s
);
    typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_DONE} sadc_state_e;
    sadc_state_e state_r;

    // sequencing with one-cycle start, store and clear pulses
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r     <= SQ_IDLE;
            s.start     <= 1'b0;
            s.ch        <= 1'b0;
            s.store     <= 2'h0;
            s.clear_run <= 1'b0;
            s.data      <= 12'h000;
        end
        else
        begin
            s.start     <= 1'b0;
            s.store     <= 2'h0;
            s.clear_run <= 1'b0;
            case (state_r)
                SQ_IDLE:
                    if (s.run && s.sel != 2'h0) // empty select idles
                    begin
                        s.ch    <= ~s.sel[0];  // channel 0 first
                        s.start <= 1'b1;
                        state_r <= SQ_WAIT;
                    end
                SQ_WAIT:
                    if (!s.run)
                        state_r <= SQ_IDLE;  // software stop
                    else if (s.done)
                    begin
                        s.store[s.ch] <= 1'b1;
                        s.data        <= s.result;
                        if (!s.ch && s.sel[1])
                        begin
                            s.ch    <= 1'b1;  // then channel 1
                            s.start <= 1'b1;
                        end
                        else if (s.repeat_sel)
                        begin
                            s.ch    <= ~s.sel[0];  // loop again
                            s.start <= 1'b1;
                        end
                        else
                        begin
                            s.clear_run <= 1'b1;  // single mode ends
                            state_r     <= SQ_DONE;
                        end
                    end
                default:
                    state_r <= SQ_IDLE;  // run bit clears meanwhile
            endcase
        end
    end
endmodule
`default_nettype wire

//--- verilog/sadc_irq.sv
// sticky event status, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none
module sadc_irq
    import sadc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic [1:0] ev,
    input  wire logic       clr_we,
    input  wire logic [1:0] clr_data,
    input  wire logic       mask_we,
    input  wire logic [1:0] mask_data,
    output logic      [1:0] status_r,
    output logic      [1:0] mask_r,
    output logic            irq_r
);
    // set wins over write-one-to-clear
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            status_r <= 2'h0;
        else
            status_r <= (status_r & ~(clr_we ? clr_data : 2'h0)) | ev;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            mask_r <= 2'h0;
        else if (mask_we)
            mask_r <= mask_data;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_r <= 1'b0;
        else
            irq_r <= |(status_r & mask_r);
    end

    a_event_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
        ev[0] |=> status_r[0]) else $error("event did not set status");
    a_irq_level: assert property (@(posedge core_clk) disable iff (!arst_n)
        ev[0] && mask_r[0] && !mask_we |=> ##1 irq_r)
        else $error("unmasked event did not raise irq");
endmodule
`default_nettype wire

//--- verilog/sadc_top.sv
// register file, bus slave and result storage of the converter
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
//Contract
// - two channels, each with own 12-bit result
// - low byte: result bits 3..0 at 7..4
// - results load only on channel completion
// - low byte read-only, reset zero, word readable
// - high byte read-only, reset zero, byte only
// - channel 1 result at next two addresses
// - first control register read/write, reset 02
// - channel select register resets to none
// - run bit starts, stops, self-clears single
// - repeat bit picks single or continuous
// - channel 0 converts before channel 1
// - empty select: power only, nothing else
module sadc_top
    import sadc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   conv_power,
    output logic                   conv_start,
    output logic                   conv_channel,
    input  wire logic              conv_done,
    input  wire logic [RES_W-1:0]  conv_result,
    output logic                   conv_irq,
    output logic                   irq
);
    sadc_seq_if sif ();

    logic [RES_W-1:0] res_r [NCH];
    logic [7:0]       con0_r;
    logic [7:0]       con1_r;
    logic [7:0]       mod0_r;
    logic [15:0]      wr_idx_r;
    logic [31:0]      wdata_r;
    logic [3:0]       wstrb_r;
    logic [15:0]      rd_idx_r;
    logic [32:0]      rd_sel;
    logic             wr_go;
    logic             run_set;
    logic [1:0]       status;
    logic [1:0]       mask;
    logic             irq_lvl;

    assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign run_set = wr_go && wstrb_r[0] && wdata_r[RUN_BIT] && wr_idx_r == IDX_CON1
        || wr_go && wstrb_r[1] && wdata_r[8 + RUN_BIT] && wr_idx_r == IDX_CON0;

    // sequencer link
    assign sif.run        = con1_r[RUN_BIT];
    assign sif.repeat_sel = con0_r[REP_BIT];
    assign sif.sel        = mod0_r[1:0];
    assign sif.done       = conv_done;
    assign sif.result     = conv_result;
    assign conv_start     = sif.start;
    assign conv_channel   = sif.ch;
    assign irq            = irq_lvl;

    sadc_seq u_seq (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .s        (sif.seq)
    );

    sadc_irq u_irq (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .ev        (sif.store),
        .clr_we    (wr_go && wstrb_r[0] && wr_idx_r == IDX_STAT),
        .clr_data  (wdata_r[1:0]),
        .mask_we   (wr_go && wstrb_r[0] && wr_idx_r == IDX_MASK),
        .mask_data (wdata_r[1:0]),
        .status_r  (status),
        .mask_r    (mask),
        .irq_r     (irq_lvl)
    );

    // per-channel result storage, loaded only on completion
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_res
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                    res_r[gi] <= '0;
                else if (sif.store[gi])
                    res_r[gi] <= sif.data;
            end
        end
    endgenerate

    // completion pulse, one cycle per stored result
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            conv_irq <= 1'b0;
        else
            conv_irq <= |sif.store;
    end

    // converter power follows the run bit
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            conv_power <= 1'b0;
        else
            conv_power <= con1_r[RUN_BIT];
    end

    // write channels: address and data taken in either order
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OK;
            wr_idx_r      <= 16'h0000;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                wr_idx_r      <= s_axi_awaddr[ADDR_W-1:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                if (wr_idx_r == IDX_R0L || wr_idx_r == IDX_R0H
                    || wr_idx_r == IDX_R1L || wr_idx_r == IDX_R1H
                    || wr_idx_r == IDX_CON0 || wr_idx_r == IDX_CON1
                    || wr_idx_r == IDX_MOD0 || wr_idx_r == IDX_STAT
                    || wr_idx_r == IDX_MASK)
                    s_axi_bresp <= RESP_OK;
                else
                    s_axi_bresp <= RESP_ERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // first control register, upper lane reaches the second
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            con0_r <= CON0_RST;
        else if (wr_go && wstrb_r[0] && wr_idx_r == IDX_CON0)
            con0_r <= wdata_r[7:0];
    end

    // run control: software write, hardware self-clear
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            con1_r <= CON1_RST;
        else if (wr_go && wstrb_r[0] && wr_idx_r == IDX_CON1)
            con1_r <= wdata_r[7:0];
        else if (wr_go && wstrb_r[1] && wr_idx_r == IDX_CON0)
            con1_r <= wdata_r[15:8];
        else if (sif.clear_run)
            con1_r[RUN_BIT] <= 1'b0;
    end

    // channel select mode, byte lane only
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            mod0_r <= MOD0_RST;
        else if (wr_go && wstrb_r[0] && wr_idx_r == IDX_MOD0)
            mod0_r <= wdata_r[7:0];
    end

    // read data mux by register index
    function automatic logic [32:0] rd_word(input logic [15:0] idx);
        logic [7:0] lo0;
        logic [7:0] lo1;
        lo0 = {res_r[0][NIB_POS-1:0], 4'h0};
        lo1 = {res_r[1][NIB_POS-1:0], 4'h0};
        if (idx == IDX_R0L)
            rd_word = {1'b0, 16'h0000, res_r[0][RES_W-1:NIB_POS], lo0};
        else if (idx == IDX_R0H)
            rd_word = {1'b0, 24'h00_0000, res_r[0][RES_W-1:NIB_POS]};
        else if (idx == IDX_R1L)
            rd_word = {1'b0, 16'h0000, res_r[1][RES_W-1:NIB_POS], lo1};
        else if (idx == IDX_R1H)
            rd_word = {1'b0, 24'h00_0000, res_r[1][RES_W-1:NIB_POS]};
        else if (idx == IDX_CON0)
            rd_word = {1'b0, 16'h0000, con1_r, con0_r};
        else if (idx == IDX_CON1)
            rd_word = {1'b0, 24'h00_0000, con1_r};
        else if (idx == IDX_MOD0)
            rd_word = {1'b0, 24'h00_0000, mod0_r};
        else if (idx == IDX_STAT)
            rd_word = {1'b0, 30'h0000_0000, status};
        else if (idx == IDX_MASK)
            rd_word = {1'b0, 30'h0000_0000, mask};
        else
            rd_word = {1'b1, 32'h0000_0000};
    endfunction

    // read word and error flag for the presented address
    always_comb
    begin
        rd_sel = rd_word(s_axi_araddr[ADDR_W-1:2]);
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OK;
            rd_idx_r      <= 16'h0000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            rd_idx_r      <= s_axi_araddr[ADDR_W-1:2];
            s_axi_rdata   <= rd_sel[31:0];
            s_axi_rresp   <= rd_sel[32] ? RESP_ERR : RESP_OK;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // properties on this block's own state and outputs
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // conversion-end situations seen from the converter pins
    sequence s_ch0_done_both;
        conv_done && !conv_channel && mod0_r[1:0] == 2'h3 && con1_r[RUN_BIT]
        && !conv_start;
    endsequence
    sequence s_last_done_loop;
        conv_done && con0_r[REP_BIT] && con1_r[RUN_BIT] && !conv_start
        && (conv_channel || !mod0_r[1]);
    endsequence
    sequence s_last_done_single;
        conv_done && !con0_r[REP_BIT] && con1_r[RUN_BIT] && !conv_start
        && (conv_channel || !mod0_r[1]);
    endsequence

    // result storage holds and loads
    a_result_hold: assert property (!sif.store[0] |=> $stable(res_r[0]))
        else $error("channel 0 result changed without completion");
    a_result_load: assert property (sif.store[1] |=> res_r[1] == $past(sif.data))
        else $error("channel 1 result not loaded");

    // read layout, against the state held when the address was taken
    a_low_nibble: assert property ($rose(s_axi_rvalid) && rd_idx_r == IDX_R0L
        |-> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[7:4] == $past(res_r[0][3:0]))
        else $error("low byte layout wrong");
    a_high_byte: assert property ($rose(s_axi_rvalid) && rd_idx_r == IDX_R0H
        |-> s_axi_rdata == {24'h00_0000, $past(res_r[0][RES_W-1:NIB_POS])})
        else $error("high byte layout wrong");
    a_ch1_word: assert property ($rose(s_axi_rvalid) && rd_idx_r == IDX_R1L
        |-> s_axi_rdata == {16'h0000, $past(res_r[1]), 4'h0})
        else $error("channel 1 word layout wrong");
    a_ch1_high: assert property ($rose(s_axi_rvalid) && rd_idx_r == IDX_R1H
        |-> s_axi_rdata == {24'h00_0000, $past(res_r[1][RES_W-1:NIB_POS])})
        else $error("channel 1 high byte layout wrong");
    a_con_word: assert property ($rose(s_axi_rvalid) && rd_idx_r == IDX_CON0
        |-> s_axi_rdata == {16'h0000, $past(con1_r), $past(con0_r)})
        else $error("control word layout wrong");
    a_stat_read: assert property ($rose(s_axi_rvalid) && rd_idx_r == IDX_STAT
        |-> s_axi_rdata == {30'h0000_0000, $past(status)})
        else $error("status read wrong");

    // sequencing of the run bit and the converter strobes
    a_run_clear: assert property (sif.clear_run && !run_set |=> !con1_r[RUN_BIT])
        else $error("run bit not cleared after single pass");
    a_single_stop: assert property
        (s_last_done_single ##1 !wr_go |=> !con1_r[RUN_BIT])
        else $error("run bit still set after single pass");
    a_start_pulse: assert property (conv_start && !conv_done |=> !conv_start)
        else $error("start strobe longer than one cycle");
    a_chan_order: assert property (s_ch0_done_both |=> conv_start && conv_channel)
        else $error("channel 1 not started after channel 0");
    a_repeat_loop: assert property (s_last_done_loop |=> conv_start)
        else $error("continuous mode did not restart");
    a_empty_select: assert property
        ((con1_r[RUN_BIT] && mod0_r[1:0] == 2'h0)[*2] |-> !conv_start && !(|sif.store))
        else $error("conversion with no channel selected");
    a_done_pulse: assert property (conv_irq |=> !conv_irq)
        else $error("completion pulse longer than one cycle");

    // bus handshakes answer and return to idle
    a_write_answer: assert property (wr_go |=> s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_write_idle: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("write channels not reopened");
    a_read_idle: assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready && !s_axi_rvalid)
        else $error("read channel not reopened");
    a_err_data: assert property ($rose(s_axi_rvalid) && s_axi_rresp == RESP_ERR
        |-> s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");
endmodule
`default_nettype wire

//--- test/test_sar_adc_result_registers.sv
// self-checking bench for the converter register and result block
`timescale 1ns/10ps
`default_nettype none
module test_sar_adc_result_registers
    import sadc_pkg::*;
;
    logic              core_clk;
    logic              arst_n;
    logic [ADDR_W-1:0] s_axi_awaddr;
    logic              s_axi_awvalid;
    logic              s_axi_awready;
    logic [31:0]       s_axi_wdata;
    logic [3:0]        s_axi_wstrb;
    logic              s_axi_wvalid;
    logic              s_axi_wready;
    logic [1:0]        s_axi_bresp;
    logic              s_axi_bvalid;
    logic              s_axi_bready;
    logic [ADDR_W-1:0] s_axi_araddr;
    logic              s_axi_arvalid;
    logic              s_axi_arready;
    logic [31:0]       s_axi_rdata;
    logic [1:0]        s_axi_rresp;
    logic              s_axi_rvalid;
    logic              s_axi_rready;
    logic              conv_power;
    logic              conv_start;
    logic              conv_channel;
    logic              conv_done;
    logic [RES_W-1:0]  conv_result;
    logic              conv_irq;
    logic              irq;
    int                fails;
    int                checks;
    int                n_irq;
    int                n0;
    logic              q_ch[$];

    sadc_top u_sadc_top (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_power, .conv_start, .conv_channel,
        .conv_done, .conv_result, .conv_irq, .irq);

    // 200 MHz clock
    always #2.5 core_clk = ~core_clk;

    // log started channels and completion pulse cycles
    always @(posedge core_clk)
    begin
        if (conv_start === 1'b1)
            q_ch.push_back(conv_channel);
        if (conv_irq === 1'b1)
            n_irq++;
    end

    task automatic final_report();
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one clock with a bound on the whole wait
    task automatic tick(inout int n);
        @(posedge core_clk);
        n++;
        if (n > 300)
        begin
            fails++;
            final_report();
        end
    endtask

    // expected 16-bit result word as the bus shows it
    function automatic logic [31:0] ew(input logic [11:0] r);
        return {16'h0, r[11:4], r[3:0], 4'h0};
    endfunction

    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] st,
                      input logic [1:0] er = RESP_OK);
        int n;
        n = 0;
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= st;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            tick(n);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
                      input logic [1:0] er = RESP_OK);
        int n;
        n = 0;
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            tick(n);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge core_clk);
    endtask

    // answer the next started conversion on the expected channel
    task automatic conv(input logic ch, input logic [11:0] res);
        int n;
        n = 0;
        while (q_ch.size() == 0)
            tick(n);
        chk({31'h0, q_ch.pop_front()}, {31'h0, ch});
        repeat (3) @(posedge core_clk);
        conv_done   <= 1'b1;
        conv_result <= res;
        @(posedge core_clk);
        conv_done   <= 1'b0;
        conv_result <= ~res;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic t_reset();
        rd(IDX_R0L, 32'h0);
        rd(IDX_R0H, 32'h0);
        rd(IDX_R1L, 32'h0);
        rd(IDX_R1H, 32'h0);
        rd(IDX_CON0, {24'h0, CON0_RST});
        rd(IDX_CON1, 32'h0);
        rd(IDX_MOD0, 32'h0);
        rd(IDX_STAT, 32'h0);
        rd(IDX_MASK, 32'h0);
        rd(16'hf2e0, 32'h0, RESP_ERR);
        chk({31'h0, conv_power}, 32'h0);
    endtask

    task automatic t_access();
        wr(IDX_R0L, 32'hffff_ffff, 4'hf);
        wr(IDX_R1H, 32'hffff_ffff, 4'hf);
        rd(IDX_R0L, 32'h0);
        rd(IDX_R1H, 32'h0);
        wr(IDX_CON0, 32'h0000_fe03, 4'h3);
        rd(IDX_CON0, 32'h0000_fe03);
        rd(IDX_CON1, 32'h0000_00fe);
        wr(IDX_CON0, 32'h0000_0002, 4'h3);
        rd(IDX_CON0, 32'h0000_0002);
        wr(16'hf2e0, 32'h0, 4'hf, RESP_ERR);
    endtask

    task automatic t_single();
        wr(IDX_MASK, 32'h3, 4'h1);
        wr(IDX_MOD0, 32'h1, 4'h1);
        n0 = n_irq;
        wr(IDX_CON1, 32'h1, 4'h1);
        conv(1'b0, 12'habc);
        chk(q_ch.size(), 32'h0);
        chk(n_irq - n0, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd(IDX_CON1, 32'h0);
        rd(IDX_R0L, ew(12'habc));
        rd(IDX_R0H, 32'hab);
        rd(IDX_R1L, 32'h0);
        rd(IDX_STAT, 32'h1);
        wr(IDX_STAT, 32'h1, 4'h1);
        rd(IDX_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_both();
        wr(IDX_MOD0, 32'h3, 4'h1);
        n0 = n_irq;
        wr(IDX_CON1, 32'h1, 4'h1);
        conv(1'b0, 12'h5a5);
        conv(1'b1, 12'ha5a);
        chk(n_irq - n0, 32'h2);
        rd(IDX_CON1, 32'h0);
        rd(IDX_R0L, ew(12'h5a5));
        rd(IDX_R1L, ew(12'ha5a));
        rd(IDX_R1H, 32'ha5);
        rd(IDX_STAT, 32'h3);
        conv_done   <= 1'b1;
        conv_result <= 12'hfff;
        @(posedge core_clk);
        conv_done   <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(IDX_R0L, ew(12'h5a5));
        rd(IDX_R1L, ew(12'ha5a));
        wr(IDX_STAT, 32'h3, 4'h1);
    endtask

    task automatic t_empty();
        wr(IDX_MOD0, 32'h0, 4'h1);
        wr(IDX_CON1, 32'h1, 4'h1);
        repeat (20) @(posedge core_clk);
        chk(q_ch.size(), 32'h0);
        chk({31'h0, conv_power}, 32'h1);
        rd(IDX_CON1, 32'h1);
        rd(IDX_STAT, 32'h0);
        wr(IDX_CON1, 32'h0, 4'h1);
        repeat (3) @(posedge core_clk);
        chk({31'h0, conv_power}, 32'h0);
    endtask

    task automatic t_repeat();
        wr(IDX_CON0, 32'h1, 4'h1);
        wr(IDX_MOD0, 32'h2, 4'h1);
        n0 = n_irq;
        wr(IDX_CON1, 32'h1, 4'h1);
        conv(1'b1, 12'h123);
        conv(1'b1, 12'h456);
        wr(IDX_CON1, 32'h0, 4'h1);
        repeat (3) @(posedge core_clk);
        rd(IDX_CON1, 32'h0);
        rd(IDX_R1L, ew(12'h456));
        chk(n_irq - n0, 32'h2);
        q_ch.delete();
        wr(IDX_CON0, 32'h2, 4'h1);
        wr(IDX_STAT, 32'h3, 4'h1);
    endtask

    // reset, then every scenario in turn
    initial
    begin
        core_clk      = 1'b0;
        arst_n        = 1'b0;
        s_axi_awaddr  = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        conv_done     = 1'b0;
        conv_result   = 12'h0;
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_access();
        t_single();
        t_both();
        t_empty();
        t_repeat();
        final_report();
    end
endmodule
`default_nettype wire
